// >>> hdl/mgd_gate_ctrl.sv
// Summary of operation
// R01: On commutation, switch on the conducting-diode low FET; mirror high.
// R02: Rectify after a margin; stop early when the comparator drops.
// R03: High-only PWM: low-side FET on while its diode conducts in off time.
// R04: Complementary PWM: low-side FET off when decaying current nears zero.
// R05: Limit trip active whenever the summed current comparator is high outside blanking.
// R06: After a trip, keep all high-side FETs off until the next PWM cycle.
// R07: During the hold, low-side behaviour follows the recirculation select.
// R08: Brake mode: low-side FETs on while high-side FETs are held off.
// R09: High-Z mode: low-side FETs off while high-side FETs are held off.
// R10: Ignore the trip for a blanking time after a high-side PWM input turns active.
// R11: At full duty, an internal restart clock re-enables the held high side.
// R12: Register variant selects a 20 kHz or 40 kHz restart clock.
// R13: Pin variant fixes the restart clock at 20 kHz.
// R14: Demagnetization works only when both rectification enables are set.
// R15: High comparator flags current to supply; low flags ground current.
// R16: A high-side PWM rising edge, or restart tick at full duty, starts a new cycle.
// R17: Blanking and margin are cycle counts of the device clock.
`timescale 1ns/1ps
module mgd_gate_ctrl #(
  parameter int RESTART_SLOW_CYC = mgd_pkg::RESTART_SLOW_CYC,
  parameter int RESTART_FAST_CYC = mgd_pkg::RESTART_FAST_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mgd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PWM inputs from the controller, per phase
  input wire logic [2:0] pwm_hi,
  input wire logic [2:0] pwm_lo,
  // Analog comparator outputs
  input wire logic [2:0] high_side_demag_comparator,
  input wire logic [2:0] low_side_demag_comparator,
  input wire logic limit_trip,
  // Gate drive
  output logic [2:0] gate_hi,
  output logic [2:0] gate_lo
);

  logic [mgd_pkg::IN_W-1:0] in_s;
  logic [2:0] pwm_hi_s;
  logic [2:0] pwm_lo_s;
  logic [2:0] hs_dem;
  logic [2:0] ls_dem;
  logic trip_s;
  logic tick;

  mgd_sync2 #(.W(mgd_pkg::IN_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({limit_trip, low_side_demag_comparator,
               high_side_demag_comparator, pwm_lo, pwm_hi}),
    .sync_out(in_s)
  );

  assign pwm_hi_s = in_s[2:0];
  assign pwm_lo_s = in_s[5:3];
  assign hs_dem = in_s[8:6]; // R15
  assign ls_dem = in_s[11:9]; // R15
  assign trip_s = in_s[12]; // R05

  // Register file
  logic [mgd_pkg::CTRL_W-1:0] ctrl_q;
  logic [mgd_pkg::CTRL_W-1:0] ctrl_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [mgd_pkg::STAT_W-1:0] status;
  logic demag_en;
  logic brake_sel;
  logic fast_sel;

  function automatic logic addr_hit(input logic [mgd_pkg::ADDR_W-1:0] a);
    addr_hit = (a == mgd_pkg::CTRL_OFS) || (a == mgd_pkg::STAT_OFS);
  endfunction : addr_hit

  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    if (psel && penable && pwrite && pstrb[0] &&
        paddr == mgd_pkg::CTRL_OFS) begin
      ctrl_d = pwdata[mgd_pkg::CTRL_W-1:0];
    end
    // Read data is captured in the setup cycle so prdata is a flop
    if (psel && !penable && !pwrite) begin
      rdata_d = '0;
      if (paddr == mgd_pkg::CTRL_OFS) begin
        rdata_d[mgd_pkg::CTRL_W-1:0] = ctrl_q;
      end else if (paddr == mgd_pkg::STAT_OFS) begin
        rdata_d[mgd_pkg::STAT_W-1:0] = status;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= mgd_pkg::CTRL_RST;
      rdata_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit(paddr);

  assign demag_en = ctrl_q[mgd_pkg::CTRL_SYNC_BIT] &&
                    ctrl_q[mgd_pkg::CTRL_ASYNC_BIT]; // R14
  assign brake_sel = ctrl_q[mgd_pkg::CTRL_RECIR_BIT];
  // Pin-configured parts ignore the duty select and stay slow
  assign fast_sel = ctrl_q[mgd_pkg::CTRL_DUTY_BIT] &&
                    !ctrl_q[mgd_pkg::CTRL_PINCFG_BIT]; // R12 R13

  mgd_restart_tick #(
    .SLOW_CYC(RESTART_SLOW_CYC),
    .FAST_CYC(RESTART_FAST_CYC)
  ) u_restart (
    .pclk(pclk),
    .presetn(presetn),
    .fast_sel(fast_sel),
    .tick(tick)
  );

  // Cycle-by-cycle current limit
  logic [2:0] hi_prev_q;
  logic edge_seen_q;
  logic edge_seen_d;
  logic hold_q;
  logic hold_d;
  logic [mgd_pkg::CNT_W-1:0] blank_q;
  logic [mgd_pkg::CNT_W-1:0] blank_d;
  logic cycle_start;
  logic blanking;

  always_comb begin
    blanking = (blank_q != '0);
    // A tick restarts only when no edge came since the last tick,
    // so normal PWM is never chopped by the internal clock
    cycle_start = |(pwm_hi_s & ~hi_prev_q) ||
                  (tick && !edge_seen_q && |pwm_hi_s); // R16 R11
    if (tick) begin
      edge_seen_d = 1'b0;
    end else begin
      edge_seen_d = edge_seen_q || |(pwm_hi_s & ~hi_prev_q);
    end
    if (cycle_start) begin
      blank_d = mgd_pkg::BLANK_LOAD; // R10 R17
      hold_d = 1'b0; // R06
    end else begin
      blank_d = blanking ? blank_q - 1'b1 : blank_q;
      hold_d = hold_q || (trip_s && !blanking); // R05 R06 R10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_prev_q <= '0;
      edge_seen_q <= 1'b0;
      hold_q <= 1'b0;
      blank_q <= '0;
    end else begin
      hi_prev_q <= pwm_hi_s;
      edge_seen_q <= edge_seen_d;
      hold_q <= hold_d;
      blank_q <= blank_d;
    end
  end

  // Active demagnetization per phase
  mgd_pkg::mgd_sr_state_t lo_st_q [3];
  mgd_pkg::mgd_sr_state_t lo_st_d [3];
  mgd_pkg::mgd_sr_state_t hi_st_q [3];
  mgd_pkg::mgd_sr_state_t hi_st_d [3];
  logic [2:0][mgd_pkg::CNT_W-1:0] lo_cnt_q;
  logic [2:0][mgd_pkg::CNT_W-1:0] lo_cnt_d;
  logic [2:0][mgd_pkg::CNT_W-1:0] hi_cnt_q;
  logic [2:0][mgd_pkg::CNT_W-1:0] hi_cnt_d;
  logic [2:0] async_arm_q;
  logic [2:0] async_arm_d;
  logic [2:0] async_cut_q;
  logic [2:0] async_cut_d;
  logic [2:0] lo_sr_on;
  logic [2:0] hi_sr_on;

  function automatic mgd_pkg::mgd_sr_state_t sr_next(
    input mgd_pkg::mgd_sr_state_t st,
    input logic start,
    input logic done,
    input logic keep
  );
    sr_next = st;
    unique case (st)
      mgd_pkg::SR_IDLE: begin
        if (start) sr_next = mgd_pkg::SR_WAIT;
      end
      mgd_pkg::SR_WAIT: begin
        if (!start) sr_next = mgd_pkg::SR_IDLE;
        else if (done) sr_next = mgd_pkg::SR_ON; // R02
      end
      mgd_pkg::SR_ON: begin
        if (!keep) sr_next = mgd_pkg::SR_IDLE; // R02
      end
      default: sr_next = mgd_pkg::SR_IDLE;
    endcase
  endfunction : sr_next

  always_comb begin
    logic lo_arm;
    logic hi_arm;
    lo_arm = 1'b0;
    hi_arm = 1'b0;
    for (int p = 0; p < 3; p++) begin
      // Low-side diode conducts while the low command is off and the high side is off or held
      lo_arm = demag_en && ls_dem[p] && !pwm_lo_s[p] &&
               !(pwm_hi_s[p] && !hold_q); // R01 R03 R14
      lo_st_d[p] = sr_next(lo_st_q[p], lo_arm,
                           lo_cnt_q[p] == mgd_pkg::MARGIN_LAST,
                           lo_arm); // R02
      lo_cnt_d[p] = (lo_st_q[p] == mgd_pkg::SR_WAIT) ?
                    lo_cnt_q[p] + 1'b1 : '0; // R17
      // High side is never rectified while the limit holds it off
      hi_arm = demag_en && hs_dem[p] && !pwm_hi_s[p] &&
               !pwm_lo_s[p] && !hold_q; // R01 R14
      hi_st_d[p] = sr_next(hi_st_q[p], hi_arm,
                           hi_cnt_q[p] == mgd_pkg::MARGIN_LAST,
                           hi_arm); // R02
      hi_cnt_d[p] = (hi_st_q[p] == mgd_pkg::SR_WAIT) ?
                    hi_cnt_q[p] + 1'b1 : '0;
      // Arm once forward current is seen, cut when it fades
      async_arm_d[p] = demag_en && pwm_lo_s[p] &&
                       (async_arm_q[p] || ls_dem[p]); // R04
      async_cut_d[p] = demag_en && pwm_lo_s[p] &&
                       (async_cut_q[p] ||
                        (async_arm_q[p] && !ls_dem[p])); // R04
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < 3; p++) begin
        lo_st_q[p] <= mgd_pkg::SR_IDLE;
        hi_st_q[p] <= mgd_pkg::SR_IDLE;
      end
      lo_cnt_q <= '0;
      hi_cnt_q <= '0;
      async_arm_q <= '0;
      async_cut_q <= '0;
    end else begin
      lo_st_q <= lo_st_d;
      hi_st_q <= hi_st_d;
      lo_cnt_q <= lo_cnt_d;
      hi_cnt_q <= hi_cnt_d;
      async_arm_q <= async_arm_d;
      async_cut_q <= async_cut_d;
    end
  end

  // Gate drive
  logic [2:0] gate_hi_q;
  logic [2:0] gate_hi_d;
  logic [2:0] gate_lo_q;
  logic [2:0] gate_lo_d;

  always_comb begin
    status = '0;
    for (int p = 0; p < 3; p++) begin
      lo_sr_on[p] = (lo_st_q[p] == mgd_pkg::SR_ON);
      hi_sr_on[p] = (hi_st_q[p] == mgd_pkg::SR_ON);
      gate_hi_d[p] = !hold_q && (pwm_hi_s[p] || hi_sr_on[p]); // R06
      if (hold_q) begin
        gate_lo_d[p] = brake_sel; // R07 R08 R09
      end else begin
        gate_lo_d[p] = (pwm_lo_s[p] && !async_cut_q[p]) ||
                       lo_sr_on[p]; // R01 R03 R04
      end
      // Never both FETs of one leg, whatever the inputs say
      if (gate_hi_d[p]) begin
        gate_lo_d[p] = 1'b0;
      end
      status[mgd_pkg::STAT_LO_SR_LSB + p] = lo_sr_on[p];
      status[mgd_pkg::STAT_HI_SR_LSB + p] = hi_sr_on[p];
      status[mgd_pkg::STAT_ACUT_LSB + p] = async_cut_q[p];
    end
    status[mgd_pkg::STAT_HOLD_BIT] = hold_q;
    status[mgd_pkg::STAT_BLANK_BIT] = blanking;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_hi_q <= '0;
      gate_lo_q <= '0;
    end else begin
      gate_hi_q <= gate_hi_d;
      gate_lo_q <= gate_lo_d;
    end
  end

  assign gate_hi = gate_hi_q;
  assign gate_lo = gate_lo_q;

endmodule : mgd_gate_ctrl

// >>> hdl/mgd_pkg.sv
package mgd_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  // Restart clock periods: 20 kHz and 40 kHz
  localparam int RESTART_SLOW_NS = 50000;
  localparam int RESTART_FAST_NS = 25000;
  localparam int RESTART_SLOW_CYC = RESTART_SLOW_NS / CLK_PERIOD_NS;
  localparam int RESTART_FAST_CYC = RESTART_FAST_NS / CLK_PERIOD_NS;
  // Least times, so the cycle counts round up
  localparam int BLANK_NS = 200;
  localparam int MARGIN_NS = 100;
  localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MARGIN_CYC =
    (MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] BLANK_LOAD = CNT_W'(BLANK_CYC);
  localparam logic [CNT_W-1:0] MARGIN_LAST = CNT_W'(MARGIN_CYC - 1);
  localparam int RST_W = 16;

  // Register map (byte addresses)
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STAT_OFS = 12'h004;

  // Control register fields
  localparam int CTRL_W = 5;
  localparam int CTRL_SYNC_BIT = 0;
  localparam int CTRL_ASYNC_BIT = 1;
  localparam int CTRL_RECIR_BIT = 2;
  localparam int CTRL_DUTY_BIT = 3;
  localparam int CTRL_PINCFG_BIT = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h04;

  // Status register fields
  localparam int STAT_W = 11;
  localparam int STAT_HOLD_BIT = 0;
  localparam int STAT_BLANK_BIT = 1;
  localparam int STAT_LO_SR_LSB = 2;
  localparam int STAT_HI_SR_LSB = 5;
  localparam int STAT_ACUT_LSB = 8;

  // Input synchroniser layout
  localparam int IN_W = 13;

  typedef enum logic [1:0] {
    SR_IDLE = 2'b00,
    SR_WAIT = 2'b01,
    SR_ON = 2'b10
  } mgd_sr_state_t;

endpackage : mgd_pkg

// >>> hdl/mgd_sync2.sv
`timescale 1ns/1ps
module mgd_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : mgd_sync2

// >>> hdl/mgd_restart_tick.sv
`timescale 1ns/1ps
module mgd_restart_tick #(
  parameter int SLOW_CYC = mgd_pkg::RESTART_SLOW_CYC,
  parameter int FAST_CYC = mgd_pkg::RESTART_FAST_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control and tick
  input wire logic fast_sel,
  output logic tick
);

  logic [mgd_pkg::RST_W-1:0] cnt_q;
  logic [mgd_pkg::RST_W-1:0] cnt_d;
  logic [mgd_pkg::RST_W-1:0] last;
  logic tick_q;
  logic tick_d;

  always_comb begin
    last = fast_sel ? mgd_pkg::RST_W'(FAST_CYC - 1)
                    : mgd_pkg::RST_W'(SLOW_CYC - 1);
    // Greater-or-equal so a period change never strands the counter
    tick_d = (cnt_q >= last);
    cnt_d = tick_d ? '0 : cnt_q + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : mgd_restart_tick

// >>> verif/mgd_pwm_src.sv
`timescale 1ns/1ps
module mgd_pwm_src #(
  parameter int PER = 64,
  parameter int ON = 48
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // 0 idle, 1 high-side pwm, 2 full duty, 3 low side on
  input wire logic [1:0] mode,
  // Phase commands
  output logic [2:0] pwm_hi,
  output logic [2:0] pwm_lo
);
  logic [7:0] cnt_q;
  // Only phase 0 switches, so every edge seen is a known cycle start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      pwm_hi <= 3'h0;
      pwm_lo <= 3'h0;
    end else begin
      cnt_q <= (cnt_q == 8'(PER - 1)) ? 8'h00 : cnt_q + 8'h01;
      pwm_hi <= {2'h0, (mode == 2'h1 && cnt_q < 8'(ON)) || mode == 2'h2};
      pwm_lo <= {2'h0, mode == 2'h3};
    end
  end
endmodule : mgd_pwm_src

// >>> verif/mgd_gate_monitor.sv
`timescale 1ns/1ps
module mgd_gate_monitor #(
  parameter int RESTART_FAST_CYC = 2500
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register writes
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mgd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // Pins
  input wire logic [2:0] pwm_hi,
  input wire logic [2:0] pwm_lo,
  input wire logic [2:0] high_side_demag_comparator,
  input wire logic [2:0] low_side_demag_comparator,
  input wire logic limit_trip,
  input wire logic [2:0] gate_hi,
  input wire logic [2:0] gate_lo
);
  // Shadow of the control bits, seen from the bus side only
  logic [2:0] ctrl_q;
  logic [2:0] hi_q;
  logic [7:0] since_q;
  logic both_en;
  logic recir;
  assign both_en = &ctrl_q[1:0];
  assign recir = ctrl_q[2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 3'h4;
      hi_q <= 3'h0;
      since_q <= 8'hff;
    end else begin
      hi_q <= pwm_hi;
      if (|(pwm_hi & ~hi_q))
        since_q <= 8'h00;
      else if (since_q != 8'hff)
        since_q <= since_q + 8'h01;
      if (psel && penable && pwrite && pstrb[0] &&
          paddr == mgd_pkg::CTRL_OFS)
        ctrl_q <= pwdata[2:0];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_tripped;
    (limit_trip && low_side_demag_comparator == 3'h0) [*6];
  endsequence
  // Upper bound keeps a full-duty restart out of the window
  sequence s_late;
    since_q >= 8'h1e && since_q < 8'(RESTART_FAST_CYC);
  endsequence
  sequence s_edge;
    $rose(pwm_hi[0]) ##0 pwm_hi[0] [*8];
  endsequence
  sequence s_armed;
    (pwm_lo[0] && low_side_demag_comparator[0]) [*4];
  endsequence
  sequence s_decay;
    (pwm_lo[0] && !low_side_demag_comparator[0]) [*5];
  endsequence
  AST_HOLD: assert property (s_tripped ##0 s_late |-> gate_hi == 3'h0)
    else $error("high side not held off after limit trip");
  AST_RECIR: assert property (s_tripped ##0 s_late |->
    gate_lo == {3{recir}}) else $error("low side ignores recirculation");
  AST_BLANK: assert property (s_edge |-> gate_hi[0] [*4])
    else $error("high side not driven after pwm edge");
  AST_HI_SRC: assert property ((gate_hi & ~($past(pwm_hi, 3) |
    $past(high_side_demag_comparator, 3) | $past(pwm_hi, 4) |
    $past(high_side_demag_comparator, 4))) == 3'h0)
    else $error("high side on without cause");
  AST_LO_SRC: assert property (!recir && !$past(recir, 4) |->
    (gate_lo & ~($past(pwm_lo, 3) | $past(low_side_demag_comparator, 3) |
    $past(pwm_lo, 4) | $past(low_side_demag_comparator, 4))) == 3'h0)
    else $error("low side on without cause");
  AST_NO_DEMAG: assert property (!both_en && !$past(both_en, 4) &&
    !recir && !$past(recir, 4) |-> (gate_lo & ~$past(pwm_lo, 3)) == 3'h0)
    else $error("rectification while disabled");
  AST_MARGIN: assert property (!recir |-> (gate_lo & ~$past(gate_lo) &
    ~$past(pwm_lo, 3) & ~$past(low_side_demag_comparator, 10)) == 3'h0)
    else $error("rectification before margin");
  AST_CUT: assert property (both_en throughout (s_armed ##1 s_decay)
    |-> !gate_lo[0]) else $error("low side not cut near zero current");
endmodule : mgd_gate_monitor
bind mgd_gate_ctrl mgd_gate_monitor #(.RESTART_FAST_CYC(RESTART_FAST_CYC))
  mgd_gate_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .pwm_hi(pwm_hi), .pwm_lo(pwm_lo),
  .high_side_demag_comparator(high_side_demag_comparator),
  .low_side_demag_comparator(low_side_demag_comparator),
  .limit_trip(limit_trip), .gate_hi(gate_hi), .gate_lo(gate_lo));

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int SLOW = 80;
  localparam int FAST = 40;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic limit_trip;
  logic [mgd_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic [2:0] pwm_hi, pwm_lo, gate_hi, gate_lo, hsc, lsc;
  logic [1:0] mode;
  int bad_count, samples_checked;
  mgd_gate_ctrl #(.RESTART_SLOW_CYC(SLOW), .RESTART_FAST_CYC(FAST))
    mgd_gate_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_hi(pwm_hi), .pwm_lo(pwm_lo), .high_side_demag_comparator(hsc),
    .low_side_demag_comparator(lsc), .limit_trip(limit_trip),
    .gate_hi(gate_hi), .gate_lo(gate_lo));
  mgd_pwm_src mgd_pwm_src_inst (.pclk(pclk), .presetn(presetn),
    .mode(mode), .pwm_hi(pwm_hi), .pwm_lo(pwm_lo));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // Bounded wait for a level on phase 0 high-side gate
  task automatic wt(input logic v, inout int n);
    while (gate_hi[0] !== v && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) bad_count++;
  endtask : wt
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic t_regs;
    apb(1'b0, mgd_pkg::CTRL_OFS, 32'h0, 4'hf);
    chk("ctrl reset", r, 32'(mgd_pkg::CTRL_RST));
    apb(1'b1, mgd_pkg::CTRL_OFS, 32'hffff_ffff, 4'h0);
    apb(1'b1, mgd_pkg::STAT_OFS, 32'hffff_ffff, 4'hf);
    apb(1'b0, mgd_pkg::CTRL_OFS, 32'h0, 4'hf);
    chk("ctrl kept", {r[31:1], e}, 32'h4);
    apb(1'b0, 12'h008, 32'h0, 4'hf);
    chk("unmapped", {r[30:0], e}, 32'h1);
  endtask : t_regs
  task automatic t_rect;
    for (int c = 3; c >= 1; c -= 2) begin
      apb(1'b1, mgd_pkg::CTRL_OFS, 32'(c), 4'hf);
      lsc <= 3'h1;
      hsc <= 3'h2;
      cyc(14);
      chk("margin", {gate_hi, gate_lo}, 32'h0);
      cyc(10);
      chk("rectify", {gate_hi, gate_lo}, c == 3 ? 32'h11 : 32'h0);
      lsc <= 3'h0;
      hsc <= 3'h0;
      cyc(5);
      chk("early stop", {gate_hi, gate_lo}, 32'h0);
    end
  endtask : t_rect
  task automatic t_cut;
    apb(1'b1, mgd_pkg::CTRL_OFS, 32'h3, 4'hf);
    mode <= 2'h3;
    cyc(6);
    lsc <= 3'h1;
    cyc(6);
    chk("lo armed", gate_lo, 32'h1);
    lsc <= 3'h0;
    cyc(6);
    chk("lo cut", gate_lo, 32'h0);
    mode <= 2'h0;
    cyc(6);
  endtask : t_cut
  // Trip held across the edge, so blanking alone lets the high side on
  task automatic t_limit;
    int n;
    for (int b = 1; b >= 0; b--) begin
      apb(1'b1, mgd_pkg::CTRL_OFS, 32'(b << 2), 4'hf);
      limit_trip <= 1'b1;
      mode <= 2'h1;
      n = 0;
      wt(1'b1, n);
      wt(1'b0, n);
      wt(1'b1, n);
      cyc(6);
      chk("blanked", gate_hi, 32'h1);
      cyc(24);
      chk("held", gate_hi, 32'h0);
      chk("recirc", gate_lo, {3{b[0]}});
      limit_trip <= 1'b0;
      n = 0;
      wt(1'b1, n);
      chk("next cycle", n < 40, 32'h1);
      chk("hold kept", n > 25, 32'h1);
      mode <= 2'h0;
    end
  endtask : t_limit
  task automatic t_full;
    int n;
    logic [4:0] cfg [3] = '{5'h04, 5'h0c, 5'h1c};
    int per [3] = '{SLOW, FAST, SLOW};
    limit_trip <= 1'b1;
    mode <= 2'h2;
    foreach (cfg[i]) begin
      apb(1'b1, mgd_pkg::CTRL_OFS, 32'(cfg[i]), 4'hf);
      n = 0;
      repeat (2) begin
        wt(1'b0, n);
        wt(1'b1, n);
      end
      n = 0;
      wt(1'b0, n);
      wt(1'b1, n);
      chk("restart period", n, per[i]);
    end
    limit_trip <= 1'b0;
    mode <= 2'h0;
  endtask : t_full
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  initial begin
    {psel, penable, pwrite, limit_trip, presetn} = 5'h0;
    {paddr, pwdata, pstrb, mode, hsc, lsc} = '0;
    bad_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_rect;
    t_cut;
    t_limit;
    t_full;
    wrap_up;
  end
  initial begin
    #400000;
    bad_count++;
    wrap_up;
  end
endmodule : testbench
